// ---- hw/pbg_bridge.v ----
// Purpose: Decode host chip-select accesses into peripheral bus cycles
// Assumes: Host async 16-bit accesses, 25 MHz clock, sync active-low reset
// Notes: Host must add wait states to cover input sync plus strobe time
// Function
// (RULE_01) Respond only inside one 32 MB chip-select region.
// (RULE_02) Host drives the region as 16-bit asynchronous bus.
// (RULE_03) Host holds region select at least 150 ns per access.
// (RULE_04) Host has byte enables asserted when region select goes active.
// (RULE_05) Host drops byte enables half clock before select on writes.
// (RULE_06) No multiplexed or burst transfers exist on this bus.
// (RULE_07) Low enable qualifies bits 7..0, high enable bits 15..8.
// (RULE_08) Drive 3-bit peripheral address and two-way 8-bit data bus.
// (RULE_09) I/O read strobe during I/O reads and Ethernet DMA reads.
// (RULE_10) I/O write strobe only during I/O writes.
// (RULE_11) Memory read or write strobe during Ethernet memory-mode cycles.
// (RULE_12) DMA address enable held throughout Ethernet DMA transfers.
// (RULE_13) I/O and memory cycles carry byte or word sizes.
// (RULE_14) DMA read is word only with DMA acknowledge asserted.
// (RULE_15) Forward Ethernet DMA request to the host request output.
// (RULE_16) DMA-space read with request active asserts DMA acknowledge.
// (RULE_17) UART: decode, pass data both ways, steer correct byte lane.
// (RULE_18) Ethernet I/O mode and memory mode each get own space.
// (RULE_19) Host does one dummy odd byte read after reset.
// (RULE_20) Host makes every Ethernet access a full word.
// (RULE_21) Host programs Ethernet memory base to 1000 hex.
// (RULE_22) Synth decoded and byte-steered; host uses byte transfers only.
// (RULE_23) UART A, UART B and synth selects at their offsets.
// (RULE_24) Ethernet I/O, memory and DMA spaces at their offsets.
// (RULE_25) Reset drops all selects, strobes, acknowledge; bus released.
`timescale 1ns/1ps
`include "pbg_map.vh"
module pbg_bridge #(
   parameter STROBE_CYC = `PBG_CS_MIN_CYC
) (
   input wire sys_clk_in,
   input wire nrst_in,
   input wire [`PBG_OFS_MSB:0] host_addr_in,
   input wire [15:0] host_data_in,
   output wire [15:0] host_data_out,
   output wire host_data_oe_out,
   input wire periph_region_select_n_in,
   input wire low_byte_enable_n_in,
   input wire high_byte_enable_n_in,
   input wire host_output_enable_n_in,
   input wire host_read_write_n_in,
   output wire host_dma_request_out,
   output reg [2:0] periph_addr_out,
   input wire [7:0] periph_data_in,
   output reg [7:0] periph_data_out,
   output reg periph_data_oe_out,
   output reg [11:0] net_addr_out,
   input wire [15:0] net_data_in,
   output reg [15:0] net_data_out,
   output reg net_data_oe_out,
   output reg net_byte_high_enable_n_out,
   output reg io_read_strobe_n_out,
   output reg io_write_strobe_n_out,
   output reg mem_read_strobe_n_out,
   output reg mem_write_strobe_n_out,
   output reg dma_address_enable_out,
   input wire net_dma_request_in,
   output reg net_dma_ack_n_out,
   output reg net_select_n_out,
   output reg uart_a_select_n_out,
   output reg uart_b_select_n_out,
   output reg synth_select_out
);
   // Access sequence states
   localparam ST_IDLE = 3'd0;
   localparam ST_SETUP = 3'd1;
   localparam ST_STROBE = 3'd2;
   localparam ST_CAPT = 3'd3;
   localparam ST_HOLD = 3'd4;
   localparam integer STROBE_LAST_I = STROBE_CYC - 1;
   localparam [2:0] STROBE_LAST = STROBE_LAST_I[2:0];

   // Decoded space codes
   localparam SP_NONE = 3'd0;
   localparam SP_UA = 3'd1;
   localparam SP_UB = 3'd2;
   localparam SP_NIO = 3'd3;
   localparam SP_NMEM = 3'd4;
   localparam SP_NDMA = 3'd5;
   localparam SP_SYN = 3'd6;

   reg [`PBG_SY_N-1:0] sy1_r;
   reg [`PBG_SY_N-1:0] sy2_r;
   reg [`PBG_SY_N-1:0] sy3_r;
   reg [`PBG_SY_N-1:0] syf_r;
   reg [2:0] st_r;
   reg [2:0] st_nxt;
   reg [2:0] cnt_r;
   reg [2:0] space_r;
   reg [2:0] space_nxt;
   reg rd_r;
   reg be0_r;
   reg be1_r;
   reg dma_ok_r;
   reg [`PBG_OFS_MSB:0] ofs_r;
   reg [15:0] wdata_r;
   reg [15:0] cap_data;
   reg [15:0] hout_r;
   reg hout_vld_r;
   wire cs_act;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [15:0] buf_out_data;
   wire buf_push;
   wire buf_pop;
   wire byte_dev;

   // Three-flop sync; each filtered bit moves only when its stages 2 and 3 agree
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         sy1_r <= `PBG_SY_IDLE;
         sy2_r <= `PBG_SY_IDLE;
         sy3_r <= `PBG_SY_IDLE;
         syf_r <= `PBG_SY_IDLE;
      end else begin
         sy1_r <= {net_dma_request_in, host_read_write_n_in,
                   host_output_enable_n_in, high_byte_enable_n_in,
                   low_byte_enable_n_in, periph_region_select_n_in};
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         syf_r <= (sy2_r & sy3_r) | (syf_r & (sy2_r | sy3_r));
      end
   end

   assign cs_act = ~syf_r[`PBG_SY_CS];
   // Request is forwarded after sync so the host sees a clean level
   assign host_dma_request_out = syf_r[`PBG_SY_DRQ]; // [RULE_15]

   // Address decode within the region; offset is the low 25 bits
   always @* begin
      space_nxt = SP_NONE;
      if ((host_addr_in & ~`PBG_UART_MASK) == `PBG_UA_BASE) begin
         space_nxt = SP_UA; // [RULE_23] [RULE_17]
      end else if ((host_addr_in & ~`PBG_UART_MASK) == `PBG_UB_BASE) begin
         space_nxt = SP_UB; // [RULE_23]
      end else if ((host_addr_in & ~`PBG_NET_MASK) == `PBG_NIO_BASE) begin
         space_nxt = SP_NIO; // [RULE_24] [RULE_18]
      end else if ((host_addr_in & ~`PBG_NET_MASK) == `PBG_NMEM_BASE) begin
         space_nxt = SP_NMEM; // [RULE_24] [RULE_18]
      end else if ((host_addr_in & ~`PBG_NET_MASK) == `PBG_NDMA_BASE) begin
         space_nxt = SP_NDMA; // [RULE_24]
      end else if ((host_addr_in & ~`PBG_SYN_MASK) == `PBG_SYN_BASE) begin
         space_nxt = SP_SYN; // [RULE_23] [RULE_22]
      end
   end

   assign byte_dev = (space_r == SP_UA) | (space_r == SP_UB) | (space_r == SP_SYN);

   // Sequencer; next state
   always @* begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            // Only plain async single accesses are recognised
            if (cs_act) begin
               st_nxt = ST_SETUP; // [RULE_01] [RULE_06]
            end
         end
         ST_SETUP: begin
            st_nxt = ST_STROBE;
         end
         ST_STROBE: begin
            if (cnt_r == STROBE_LAST) begin
               st_nxt = rd_r ? ST_CAPT : ST_HOLD;
            end
         end
         ST_CAPT: begin
            // Stall here while the buffer is full
            if (buf_in_ready) begin
               st_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!cs_act) begin
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers and access latches
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         st_r <= ST_IDLE;
         cnt_r <= `PBG_ZERO3;
         space_r <= SP_NONE;
         rd_r <= 1'b0;
         be0_r <= 1'b0;
         be1_r <= 1'b0;
         dma_ok_r <= 1'b0;
         ofs_r <= `PBG_ZERO25;
         wdata_r <= `PBG_ZERO16;
      end else begin
         st_r <= st_nxt;
         if (st_r == ST_STROBE) begin
            cnt_r <= cnt_r + 3'd1;
         end else begin
            cnt_r <= `PBG_ZERO3;
         end
         if ((st_r == ST_IDLE) && cs_act) begin
            // Enables are valid at select time, so latch them here
            space_r <= space_nxt; // [RULE_04]
            rd_r <= syf_r[`PBG_SY_RW];
            be0_r <= ~syf_r[`PBG_SY_BE0]; // [RULE_07]
            be1_r <= ~syf_r[`PBG_SY_BE1]; // [RULE_07]
            dma_ok_r <= syf_r[`PBG_SY_DRQ] & syf_r[`PBG_SY_RW]; // [RULE_16]
            ofs_r <= host_addr_in;
            wdata_r <= host_data_in; // [RULE_13]
         end
      end
   end

   // Read capture: byte devices mirrored onto both lanes
   always @* begin
      cap_data = `PBG_ZERO16;
      if (byte_dev) begin
         cap_data = {periph_data_in, periph_data_in}; // [RULE_17] [RULE_22]
      end else if ((space_r == SP_NIO) || (space_r == SP_NMEM)) begin
         cap_data = net_data_in; // [RULE_13]
      end else if ((space_r == SP_NDMA) && dma_ok_r) begin
         cap_data = net_data_in; // [RULE_14]
      end
   end

   assign buf_push = (st_r == ST_CAPT) & buf_in_ready;
   assign buf_pop = buf_out_valid & ~hout_vld_r;

   pbg_pair_buf #(
      .W(16)
   ) u_rbuf (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .in_data_in(cap_data),
      .in_valid_in(st_r == ST_CAPT),
      .in_ready_out(buf_in_ready),
      .out_data_out(buf_out_data),
      .out_valid_out(buf_out_valid),
      .out_ready_in(~hout_vld_r)
   );

   // Host read word holds until the select goes away
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         hout_r <= `PBG_ZERO16;
         hout_vld_r <= 1'b0;
      end else if (buf_pop) begin
         hout_r <= buf_out_data;
         hout_vld_r <= 1'b1;
      end else if ((st_r == ST_IDLE) && !cs_act) begin
         hout_vld_r <= 1'b0;
      end
   end

   assign host_data_out = hout_r;
   // Drive only while selected, reading, and output enable low
   assign host_data_oe_out = hout_vld_r & cs_act & ~syf_r[`PBG_SY_OE]; // [RULE_25]

   // Peripheral selects, strobes and data paths, all registered
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         periph_addr_out <= `PBG_ZERO3;
         periph_data_out <= `PBG_ZERO8;
         periph_data_oe_out <= 1'b0; // [RULE_25]
         net_addr_out <= `PBG_ZERO12;
         net_data_out <= `PBG_ZERO16;
         net_data_oe_out <= 1'b0; // [RULE_25]
         net_byte_high_enable_n_out <= 1'b1;
         io_read_strobe_n_out <= 1'b1; // [RULE_25]
         io_write_strobe_n_out <= 1'b1;
         mem_read_strobe_n_out <= 1'b1;
         mem_write_strobe_n_out <= 1'b1;
         dma_address_enable_out <= 1'b0;
         net_dma_ack_n_out <= 1'b1; // [RULE_25]
         net_select_n_out <= 1'b1;
         uart_a_select_n_out <= 1'b1;
         uart_b_select_n_out <= 1'b1;
         synth_select_out <= 1'b0;
      end else if ((st_nxt == ST_IDLE) || (st_r == ST_IDLE)) begin
         // Selects, strobes and drive enables idle between accesses; addresses and write data hold
         periph_data_oe_out <= 1'b0;
         net_data_oe_out <= 1'b0;
         net_byte_high_enable_n_out <= 1'b1;
         io_read_strobe_n_out <= 1'b1;
         io_write_strobe_n_out <= 1'b1;
         mem_read_strobe_n_out <= 1'b1;
         mem_write_strobe_n_out <= 1'b1;
         dma_address_enable_out <= 1'b0;
         net_dma_ack_n_out <= 1'b1;
         net_select_n_out <= 1'b1;
         uart_a_select_n_out <= 1'b1;
         uart_b_select_n_out <= 1'b1;
         synth_select_out <= 1'b0;
      end else begin
         periph_addr_out <= ofs_r[`PBG_PA_MSB:`PBG_PA_LSB]; // [RULE_08]
         // Write lane: low enable picks bits 7..0, else bits 15..8
         periph_data_out <= be0_r ? wdata_r[7:0] : wdata_r[15:8]; // [RULE_17] [RULE_07]
         periph_data_oe_out <= byte_dev & ~rd_r; // [RULE_08]
         net_addr_out <= ofs_r[`PBG_NA_MSB:`PBG_NA_LSB];
         net_data_out <= wdata_r;
         net_data_oe_out <= ~rd_r & ((space_r == SP_NIO) | (space_r == SP_NMEM));
         // Word-only DMA forces both lanes on
         net_byte_high_enable_n_out <= (space_r == SP_NDMA) ? 1'b0 : ~be1_r; // [RULE_14]
         uart_a_select_n_out <= ~(space_r == SP_UA); // [RULE_23]
         uart_b_select_n_out <= ~(space_r == SP_UB); // [RULE_23]
         synth_select_out <= (space_r == SP_SYN); // [RULE_23]
         net_select_n_out <= ~((space_r == SP_NIO) | (space_r == SP_NMEM)); // [RULE_18]
         // DMA cycle qualified by the request seen at select time
         dma_address_enable_out <= (space_r == SP_NDMA) & dma_ok_r; // [RULE_12]
         net_dma_ack_n_out <= ~((space_r == SP_NDMA) & dma_ok_r); // [RULE_16] [RULE_14]
         // Strobes live only in the strobe phase
         if (st_nxt == ST_STROBE) begin
            io_read_strobe_n_out <= ~(rd_r & ((space_r == SP_NIO) | byte_dev |
                                     ((space_r == SP_NDMA) & dma_ok_r))); // [RULE_09]
            io_write_strobe_n_out <= ~(~rd_r & ((space_r == SP_NIO) | byte_dev)); // [RULE_10]
            mem_read_strobe_n_out <= ~(rd_r & (space_r == SP_NMEM)); // [RULE_11]
            mem_write_strobe_n_out <= ~(~rd_r & (space_r == SP_NMEM)); // [RULE_11]
         end else begin
            io_read_strobe_n_out <= 1'b1;
            io_write_strobe_n_out <= 1'b1;
            mem_read_strobe_n_out <= 1'b1;
            mem_write_strobe_n_out <= 1'b1;
         end
      end
   end
endmodule // pbg_bridge

// ---- hw/pbg_pair_buf.v ----
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes: Storage is two flops addressed by read and write index
`timescale 1ns/1ps
`include "pbg_map.vh"
module pbg_pair_buf #(
   parameter W = 16
) (
   input wire sys_clk_in,
   input wire nrst_in,
   input wire [W-1:0] in_data_in,
   input wire in_valid_in,
   output wire in_ready_out,
   output wire [W-1:0] out_data_out,
   output wire out_valid_out,
   input wire out_ready_in
);
   reg [W-1:0] mem_r [0:1];
   reg wr_idx_r;
   reg rd_idx_r;
   reg [1:0] cnt_r;
   wire push;
   wire pop;

   // Honest full and empty from the fill count
   assign in_ready_out = (cnt_r != 2'd2);
   assign out_valid_out = (cnt_r != 2'd0);
   assign out_data_out = mem_r[rd_idx_r];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   // Pointers and count
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         wr_idx_r <= 1'b0;
         rd_idx_r <= 1'b0;
         cnt_r <= 2'd0;
      end else begin
         if (push) begin
            wr_idx_r <= ~wr_idx_r;
         end
         if (pop) begin
            rd_idx_r <= ~rd_idx_r;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 2'd1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 2'd1;
         end
      end
   end

   // Data store, no reset needed on payload
   always @(posedge sys_clk_in) begin
      if (push) begin
         mem_r[wr_idx_r] <= in_data_in;
      end
   end
endmodule // pbg_pair_buf

// ---- inc/pbg_map.vh ----
// Purpose: Shared constants of the peripheral bus decode bridge
// Assumes: Included by bare name from every design file
// Notes: Offsets are within the 32 MB host chip-select region
`ifndef PBG_MAP_VH
`define PBG_MAP_VH

// Region offset width, 32 MB window
`define PBG_OFS_W 25
`define PBG_OFS_MSB 24

// Device spaces, base offsets and don't-care masks
`define PBG_UA_BASE 25'h0010000
`define PBG_UB_BASE 25'h0010010
`define PBG_UART_MASK 25'h000000f
`define PBG_NIO_BASE 25'h0020000
`define PBG_NMEM_BASE 25'h0021000
`define PBG_NDMA_BASE 25'h0022000
`define PBG_NET_MASK 25'h0000fff
`define PBG_SYN_BASE 25'h0030000
`define PBG_SYN_MASK 25'h000ffff

// Field positions in the latched offset
`define PBG_PA_MSB 2
`define PBG_PA_LSB 0
`define PBG_NA_MSB 11
`define PBG_NA_LSB 0

// Reset and idle values
`define PBG_ZERO16 16'h0000
`define PBG_ZERO8 8'h00
`define PBG_ZERO3 3'h0
`define PBG_ZERO12 12'h000
`define PBG_ZERO25 25'h0000000

// Timing: host select window and derived clock count, rounded up
`define PBG_CLK_MHZ 25
`define PBG_CS_MIN_NS 150
`define PBG_CS_MIN_CYC ((`PBG_CS_MIN_NS * `PBG_CLK_MHZ + 999) / 1000)

// Positions in the synchronised input vector
`define PBG_SY_CS 0
`define PBG_SY_BE0 1
`define PBG_SY_BE1 2
`define PBG_SY_OE 3
`define PBG_SY_RW 4
`define PBG_SY_DRQ 5
`define PBG_SY_N 6
// Idle levels: selects and enables high, request low, so no false request
`define PBG_SY_IDLE 6'h1f

`endif

// ---- sim/pbg_bridge_monitor.sv ----
// Purpose: Port checks for the decode bridge
// Assumes: Bound to pbg_bridge, one clock
// Notes: Reset check keeps its own disable
`timescale 1ns/1ps
module pbg_bridge_monitor #(
   parameter STROBE_CYC = 4
) (
   input wire sys_clk_in,
   input wire nrst_in,
   input wire net_dma_request_in,
   input wire host_dma_request_out,
   input wire periph_data_oe_out,
   input wire net_byte_high_enable_n_out,
   input wire io_read_strobe_n_out,
   input wire io_write_strobe_n_out,
   input wire mem_read_strobe_n_out,
   input wire mem_write_strobe_n_out,
   input wire dma_address_enable_out,
   input wire net_dma_ack_n_out,
   input wire net_select_n_out,
   input wire uart_a_select_n_out,
   input wire uart_b_select_n_out,
   input wire synth_select_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   // All four strobes idle
   wire all_hi = io_read_strobe_n_out & io_write_strobe_n_out
      & mem_read_strobe_n_out & mem_write_strobe_n_out;
   wire any_sel = !uart_a_select_n_out | !uart_b_select_n_out
      | !net_select_n_out | synth_select_out;
   reg [3:0] low_cnt_r;
   // Length of the strobe pulse, cleared while idle
   always @(posedge sys_clk_in) begin
      if (!nrst_in || all_hi)
         low_cnt_r <= 4'h0;
      else
         low_cnt_r <= low_cnt_r + 4'h1;
   end
   a_reset_quiet: assert property (disable iff (1'b0) !nrst_in |=> all_hi &&
      any_sel == 1'b0 && net_dma_ack_n_out && !periph_data_oe_out && !dma_address_enable_out)
      else $error("outputs active after reset");
   a_iow_write_only: assert property (!io_write_strobe_n_out |->
      io_read_strobe_n_out && !dma_address_enable_out && any_sel)
      else $error("io write strobe without cause");
   a_ior_cause: assert property (!io_read_strobe_n_out |->
      io_write_strobe_n_out && (any_sel || !net_dma_ack_n_out))
      else $error("io read strobe without cause");
   a_mem_to_net: assert property ((!mem_read_strobe_n_out || !mem_write_strobe_n_out)
      |-> !net_select_n_out && io_read_strobe_n_out && io_write_strobe_n_out)
      else $error("memory strobe outside net select");
   a_ack_with_aen: assert property (!net_dma_ack_n_out |->
      dma_address_enable_out && !net_byte_high_enable_n_out && io_write_strobe_n_out)
      else $error("dma ack without word dma cycle");
   a_one_select: assert property ($onehot0({!uart_a_select_n_out,
      !uart_b_select_n_out, !net_select_n_out, synth_select_out}))
      else $error("two selects at once");
   a_strobe_len: assert property ($rose(all_hi) && $past(nrst_in) |->
      low_cnt_r == STROBE_CYC)
      else $error("strobe length wrong");
   a_dma_forward: assert property (net_dma_request_in [*8] |-> host_dma_request_out)
      else $error("dma request not forwarded");
   c_dma_ack: cover property (!net_dma_ack_n_out);
   c_mem_write: cover property (!mem_write_strobe_n_out);
   c_synth_read: cover property (synth_select_out && !io_read_strobe_n_out);
endmodule // pbg_bridge_monitor

bind pbg_bridge pbg_bridge_monitor #(.STROBE_CYC(STROBE_CYC)) mon_u (.*);

// ---- sim/pbg_host_model.sv ----
// Purpose: Host chip-select master for the bridge
// Assumes: Single asynchronous 16-bit accesses
// Notes: Released lines show inverted values
`timescale 1ns/1ps
module pbg_host_model (
   input wire sys_clk_in,
   input wire [15:0] rdat_in,
   input wire rdoe_in,
   output reg [24:0] addr_out,
   output reg [15:0] wdat_out,
   output reg sel_n_out,
   output reg be0_n_out,
   output reg be1_n_out,
   output reg oe_n_out,
   output reg rw_out
);
   // Idle bus from time zero
   initial begin
      addr_out = 25'h0000000;
      wdat_out = 16'h0000;
      sel_n_out = 1'b1;
      be0_n_out = 1'b1;
      be1_n_out = 1'b1;
      oe_n_out = 1'b1;
      rw_out = 1'b1;
   end
   // One access; long hold covers sync, strobe and buffer delay
   task access(input [24:0] a, input [15:0] wd, input [1:0] ben, input rd,
      output [15:0] q, output qoe);
      begin
         @(posedge sys_clk_in);
         addr_out <= a;
         wdat_out <= wd;
         rw_out <= rd;
         oe_n_out <= !rd;
         be0_n_out <= ben[0];
         be1_n_out <= ben[1];
         sel_n_out <= 1'b0;
         repeat (18) @(posedge sys_clk_in);
         q = rdat_in;
         qoe = rdoe_in;
         if (!rd) begin
            be0_n_out <= 1'b1;
            be1_n_out <= 1'b1;
            @(posedge sys_clk_in);
         end
         sel_n_out <= 1'b1;
         oe_n_out <= 1'b1;
         be0_n_out <= 1'b1;
         be1_n_out <= 1'b1;
         addr_out <= ~a;
         wdat_out <= ~wd;
         repeat (8) @(posedge sys_clk_in);
      end
   endtask
endmodule // pbg_host_model

// ---- sim/pbg_tb.sv ----
// Purpose: Self-checking bench for the decode bridge
// Assumes: Default strobe length, host model on host side
// Notes: Seen flags gather what fired in one access
`timescale 1ns/1ps
module tb;
   reg sys_clk;
   reg nrst = 1'b0;
   reg [7:0] pdi = 8'h5a;
   reg [15:0] ndi = 16'h1234;
   reg drq = 1'b0;
   reg clr_r = 1'b0;
   reg [9:0] seen_r;
   reg [2:0] drv_r;
   reg [7:0] pdw_r;
   reg [15:0] ndw_r, q;
   reg [11:0] na_r;
   reg [2:0] pa_r;
   reg qoe;
   integer miscompares = 0;
   integer comparisons = 0;
   wire [24:0] ha;
   wire [15:0] hw, hr, ndo;
   wire [11:0] na;
   wire [7:0] pdo;
   wire [2:0] pa;
   wire sel, be0, be1, oe, rw, hroe, dreq, pdoe, ndoe, bhe;
   wire ior, iow, memr, memw, dma_address_enable, ack, nsel, ua, ub, syn;
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   pbg_host_model host_u (.sys_clk_in(sys_clk), .rdat_in(hr), .rdoe_in(hroe),
      .addr_out(ha), .wdat_out(hw), .sel_n_out(sel), .be0_n_out(be0),
      .be1_n_out(be1), .oe_n_out(oe), .rw_out(rw));
   pbg_bridge dut_u (.sys_clk_in(sys_clk), .nrst_in(nrst), .host_addr_in(ha),
      .host_data_in(hw), .host_data_out(hr), .host_data_oe_out(hroe),
      .periph_region_select_n_in(sel), .low_byte_enable_n_in(be0),
      .high_byte_enable_n_in(be1), .host_output_enable_n_in(oe),
      .host_read_write_n_in(rw), .host_dma_request_out(dreq), .periph_addr_out(pa),
      .periph_data_in(pdi), .periph_data_out(pdo), .periph_data_oe_out(pdoe),
      .net_addr_out(na), .net_data_in(ndi), .net_data_out(ndo), .net_data_oe_out(ndoe),
      .net_byte_high_enable_n_out(bhe), .io_read_strobe_n_out(ior),
      .io_write_strobe_n_out(iow), .mem_read_strobe_n_out(memr),
      .mem_write_strobe_n_out(memw), .dma_address_enable_out(dma_address_enable),
      .net_dma_request_in(drq), .net_dma_ack_n_out(ack), .net_select_n_out(nsel),
      .uart_a_select_n_out(ua), .uart_b_select_n_out(ub), .synth_select_out(syn));
   // Record selects, strobes and driven data of one access
   always @(posedge sys_clk) begin
      if (clr_r || !nrst) begin
         seen_r <= 10'h000;
         drv_r <= 3'h0;
      end else begin
         seen_r <= seen_r | {~ua, ~ub, ~nsel, syn, ~ior, ~iow, ~memr, ~memw, dma_address_enable, ~ack};
         drv_r <= drv_r | {pdoe, ndoe, ~bhe};
      end
      if (!iow)
         pdw_r <= pdo;
      if (!iow || !memw)
         ndw_r <= ndo;
      if (!nsel)
         na_r <= na;
      if (!ua || !ub || syn)
         pa_r <= pa;
   end
   task close_out;
      begin
         $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
         if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Clear the flags, then run one host access
   task acc(input [24:0] a, input [15:0] wd, input [1:0] ben, input rd);
      begin
         @(posedge sys_clk);
         clr_r <= 1'b1;
         @(posedge sys_clk);
         clr_r <= 1'b0;
         host_u.access(a, wd, ben, rd, q, qoe);
      end
   endtask
   task t_reset;
      begin
         chk({22'h0, ua, ub, nsel, ~syn, ior, iow, memr, memw, ~dma_address_enable, ack}, 32'h3ff);
         chk({29'h0, pdoe, ndoe, ~bhe}, 32'h0);
         chk(dreq, 1'b0);
      end
   endtask
   // Odd byte read outside every space: refused
   task t_dummy;
      begin
         acc(25'h0000007, 16'h0000, 2'b01, 1'b1);
         chk(seen_r, 10'h000);
         chk(q, 16'h0000);
         chk(drv_r, 3'h1);
      end
   endtask
   task t_uart;
      begin
         acc(25'h0010003, 16'hc3a5, 2'b10, 1'b0);
         chk(seen_r, 10'h210);
         chk(drv_r, 3'h4);
         chk(pdw_r, 8'ha5);
         chk(pa_r, 3'h3);
         acc(25'h0010015, 16'hc3a5, 2'b01, 1'b0);
         chk(seen_r, 10'h110);
         chk(pdw_r, 8'hc3);
         chk(pa_r, 3'h5);
         acc(25'h0010012, 16'h0000, 2'b01, 1'b1);
         chk(seen_r, 10'h120);
         chk({qoe, q}, 17'h15a5a);
      end
   endtask
   task t_net;
      begin
         acc(25'h0020abc, 16'hbeef, 2'b00, 1'b0);
         chk(seen_r, 10'h090);
         chk(ndw_r, 16'hbeef);
         chk(na_r, 12'habc);
         chk(drv_r, 3'h3);
         acc(25'h002002c, 16'h1000, 2'b00, 1'b0);
         chk(ndw_r, 16'h1000);
         chk(na_r, 12'h02c);
         acc(25'h0021010, 16'h0000, 2'b00, 1'b1);
         chk(seen_r, 10'h088);
         chk({qoe, q}, 17'h11234);
         acc(25'h0021020, 16'h4321, 2'b00, 1'b0);
         chk(seen_r, 10'h084);
         chk(ndw_r, 16'h4321);
         chk(na_r, 12'h020);
      end
   endtask
   // DMA space refused without request, acknowledged with it
   task t_dma;
      begin
         acc(25'h0022000, 16'h0000, 2'b00, 1'b1);
         chk(seen_r & 10'h37f, 10'h000);
         chk(q, 16'h0000);
         @(posedge sys_clk);
         drq <= 1'b1;
         repeat (8) @(posedge sys_clk);
         chk(dreq, 1'b1);
         acc(25'h0022000, 16'h0000, 2'b00, 1'b1);
         chk(seen_r & 10'h37f, 10'h023);
         chk(drv_r, 3'h1);
         chk({qoe, q}, 17'h11234);
         acc(25'h0022000, 16'h5555, 2'b00, 1'b0);
         chk(seen_r & 10'h03c, 10'h000);
         drq <= 1'b0;
         repeat (8) @(posedge sys_clk);
         chk(dreq, 1'b0);
      end
   endtask
   task t_synth;
      begin
         acc(25'h0030004, 16'h0077, 2'b10, 1'b0);
         chk(seen_r, 10'h050);
         chk(pdw_r, 8'h77);
         chk(pa_r, 3'h4);
         chk(drv_r, 3'h4);
         acc(25'h0030004, 16'h0000, 2'b10, 1'b1);
         chk(seen_r, 10'h060);
         chk({qoe, q}, 17'h15a5a);
      end
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      t_reset;
      nrst <= 1'b1;
      repeat (6) @(posedge sys_clk);
      t_dummy;
      t_uart;
      t_net;
      t_dma;
      t_synth;
      close_out;
   end
   // Hang guard, far beyond the expected run
   initial begin
      repeat (5000) @(posedge sys_clk);
      miscompares = miscompares + 1;
      close_out;
   end
endmodule // tb
